// ==== rtl/sysad_pkg.sv ====
/*
 * Constants and types shared by the system address decoder and its helpers.
 * Assumes a 26-bit byte address space and a 32-bit system bus.
 */
// Summary of operation
// - power-up map: top 64KB is the config block, lowest 32MB boot flash.
// - config block resets to its default base; software may remap memory regions.
// - config block relocates to any 64KB-aligned base; decode follows new base.
// - config registers are aligned words; non-word accesses are refused.
// - bridge configuration offsets 0x2000-0x2224 decode like other registers.
// - in guest mode an external PCI host reaches a bridge register subset.
// - offsets 0x0000-0x0004 select system, 0x4000-0x4040 memory controller.
// - 0x6000-0x60FC selects WAN DMA, 0x8000-0x80FC LAN DMA.
// - offsets 0xA000-0xA0FC are reserved; nothing is selected there.
// - interrupt controller up to 0xE234, timer 0xE400-0xE410.
// - GPIO 0xE600-0xE608, switch engine 0xE800-0xE850.
// - application map: SDRAM at zero, 4MB flash, three external I/O banks.
package sysad_pkg;
    localparam int ADDR_W = 26;
    localparam int BASE_W = 10;
    localparam int OFF_W = 16;
    localparam int NSUB = 12;

    localparam logic [BASE_W-1:0] CFG_BASE_DEF = 10'h3ff;

    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    localparam logic [ADDR_W-1:0] BOOT_HI = 26'h1ffffff;
    localparam logic [ADDR_W-1:0] SDRAM_HI = 26'h0ffffff;
    localparam logic [ADDR_W-1:0] FLASH_LO = 26'h2800000;
    localparam logic [ADDR_W-1:0] FLASH_HI = 26'h2bfffff;
    localparam logic [ADDR_W-1:0] XIO0_LO = 26'h3200000;
    localparam logic [ADDR_W-1:0] XIO0_HI = 26'h35fffff;
    localparam logic [ADDR_W-1:0] XIO1_LO = 26'h3600000;
    localparam logic [ADDR_W-1:0] XIO1_HI = 26'h39fffff;
    localparam logic [ADDR_W-1:0] XIO2_LO = 26'h3a00000;
    localparam logic [ADDR_W-1:0] XIO2_HI = 26'h3feffff;

    // guest-visible slice of the bridge range
    localparam logic [OFF_W-1:0] GUEST_LO = 16'h2000;
    localparam logic [OFF_W-1:0] GUEST_HI = 16'h20fc;

    typedef enum logic [2:0] {
        REG_NONE = 3'h0,
        REG_CFG = 3'h1,
        REG_BOOT = 3'h2,
        REG_SDRAM = 3'h3,
        REG_FLASH = 3'h4,
        REG_XIO0 = 3'h5,
        REG_XIO1 = 3'h6,
        REG_XIO2 = 3'h7
    } sysad_region_t;

    typedef enum logic [3:0] {
        SUB_NONE = 4'h0,
        SUB_SYS = 4'h1,
        SUB_BRIDGE = 4'h2,
        SUB_MEMC = 4'h3,
        SUB_WDMA = 4'h4,
        SUB_LDMA = 4'h5,
        SUB_RSVD = 4'h6,
        SUB_UART = 4'h7,
        SUB_INTC = 4'h8,
        SUB_TIMER = 4'h9,
        SUB_GPIO = 4'ha,
        SUB_SWITCH = 4'hb,
        SUB_MISC = 4'hc
    } sysad_sub_t;

    // entry i selects code i+1; inclusive word ranges
    localparam logic [OFF_W-1:0] SUB_LO [NSUB] = '{16'h0000, 16'h2000, 16'h4000, 16'h6000,
        16'h8000, 16'ha000, 16'he000, 16'he200, 16'he400, 16'he600, 16'he800, 16'hea00};
    localparam logic [OFF_W-1:0] SUB_HI [NSUB] = '{16'h0004, 16'h2224, 16'h4040, 16'h60fc,
        16'h80fc, 16'ha0fc, 16'he0fc, 16'he234, 16'he410, 16'he608, 16'he850, 16'hea18};
endpackage : sysad_pkg

// ==== rtl/sysad_region_dec.sv ====
/*
 * Combinational region decode of a system bus address.
 * Assumes the caller registers the result.
 */
`timescale 1ns/1ps
module sysad_region_dec import sysad_pkg::*; (
    input wire logic [ADDR_W-1:0] addr,     // byte address
    input wire logic [BASE_W-1:0] cfg_base, // config block base, 64KB units
    input wire logic app_map,               // application map selected
    output sysad_region_t region            // decoded region
);
    always_comb begin
        region = REG_NONE;
        if (addr[ADDR_W-1:OFF_W] == cfg_base) begin
            region = REG_CFG;
        end else if (!app_map) begin
            if (addr <= BOOT_HI) begin
                region = REG_BOOT;
            end
        end else begin
            if (addr <= SDRAM_HI) begin
                region = REG_SDRAM;
            end else if (addr >= FLASH_LO && addr <= FLASH_HI) begin
                region = REG_FLASH;
            end else if (addr >= XIO0_LO && addr <= XIO0_HI) begin
                region = REG_XIO0;
            end else if (addr >= XIO1_LO && addr <= XIO1_HI) begin
                region = REG_XIO1;
            end else if (addr >= XIO2_LO && addr <= XIO2_HI) begin
                region = REG_XIO2;
            end
        end
    end
endmodule : sysad_region_dec

// ==== rtl/sysad_sub_dec.sv ====
/*
 * Combinational decode of a config block offset into its register group.
 * Assumes word-aligned offsets; the caller checks alignment.
 */
`timescale 1ns/1ps
module sysad_sub_dec import sysad_pkg::*; (
    input wire logic [OFF_W-1:0] offset, // offset within config block
    output sysad_sub_t sub               // selected register group
);
    logic [NSUB-1:0] hit;

    for (genvar i = 0; i < NSUB; i++) begin : g_range
        assign hit[i] = (offset >= SUB_LO[i]) && (offset <= SUB_HI[i]);
    end

    always_comb begin
        sub = SUB_NONE;
        for (int i = NSUB - 1; i >= 0; i--) begin
            if (hit[i]) begin
                sub = sysad_sub_t'(4'(i + 1));
            end
        end
    end
endmodule : sysad_sub_dec

// ==== rtl/sysad_decoder.sv ====
/*
 * System address decoder: region select, config block relocation, register group
 * select, word-access check and guest-mode PCI access to the bridge registers.
 * Assumes bus and PCI request signals are already on core_clk; the guest strap
 * arrives on a pin and is synchronised here.
 */
`timescale 1ns/1ps
module sysad_decoder import sysad_pkg::*; (
    input wire logic core_clk,                // 40 MHz system clock
    input wire logic rst_n,                   // async reset, active low
    input wire logic bus_req,                 // one-cycle bus access request
    input wire logic bus_write,               // access is a write
    input wire logic [ADDR_W-1:0] bus_addr,   // byte address
    input wire logic [1:0] bus_size,          // 0 byte, 1 half, 2 word
    input wire logic app_map,                 // level: application map active
    input wire logic reloc_we,                // pulse: load new config base
    input wire logic [BASE_W-1:0] reloc_base, // new config base, 64KB units
    input wire logic guest_pin,               // PCI guest strap pin
    input wire logic pci_req,                 // PCI host access request
    input wire logic pci_write,               // PCI access is a write
    input wire logic [OFF_W-1:0] pci_offset,  // PCI register offset
    output logic dec_ack,                     // access completed
    output sysad_region_t dec_region,         // region hit
    output sysad_sub_t dec_sub,               // register group hit
    output logic [OFF_W-1:0] dec_offset,      // offset within config block
    output logic dec_write,                   // write qualifier of the access
    output logic dec_sel,                     // functional target selected
    output logic dec_size_err,                // non-word config access refused
    output logic dec_rd_zero,                 // read returns zero
    output logic [BASE_W-1:0] cfg_base,       // current config base
    output logic guest_mode,                  // synchronised guest strap
    output logic pci_ack,                     // PCI access completed
    output logic pci_sel,                     // bridge register selected for PCI
    output logic pci_wr,                      // PCI write qualifier
    output logic [OFF_W-1:0] pci_off          // PCI offset passed on
);
    sysad_region_t region;
    sysad_sub_t sub;
    logic guest_meta;
    logic word_ok;
    logic cfg_hit;
    logic next_sel;
    logic next_size_err;
    logic pci_in_range;

    sysad_region_dec u_region (
        .addr(bus_addr),
        .cfg_base(cfg_base),
        .app_map(app_map),
        .region(region)
    );

    sysad_sub_dec u_sub (
        .offset(bus_addr[OFF_W-1:0]),
        .sub(sub)
    );

    // config base register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_base <= CFG_BASE_DEF;
        end else if (reloc_we) begin
            cfg_base <= reloc_base;
        end
    end

    // guest strap synchroniser
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            guest_meta <= 1'b0;
            guest_mode <= 1'b0;
        end else begin
            guest_meta <= guest_pin;
            guest_mode <= guest_meta;
        end
    end

    assign word_ok = (bus_size == SIZE_WORD) && (bus_addr[1:0] == 2'h0);
    assign cfg_hit = bus_req && (region == REG_CFG);

    always_comb begin
        next_size_err = 1'b0;
        next_sel = 1'b0;
        if (cfg_hit) begin
            next_size_err = !word_ok;
            // reserved and undecoded offsets select nothing
            next_sel = word_ok && (sub != SUB_NONE) && (sub != SUB_RSVD);
        end else if (bus_req) begin
            next_sel = (region != REG_NONE);
        end
    end

    // bus answer: every request completes one cycle later
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dec_ack <= 1'b0;
            dec_sel <= 1'b0;
            dec_size_err <= 1'b0;
            dec_rd_zero <= 1'b0;
        end else begin
            dec_ack <= bus_req;
            dec_sel <= next_sel;
            dec_size_err <= next_size_err;
            dec_rd_zero <= bus_req && !bus_write && !next_sel;
        end
    end

    // target identity, held as zero in the cycle after no request is taken
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dec_region <= REG_NONE;
            dec_sub <= SUB_NONE;
            dec_offset <= 16'h0000;
            dec_write <= 1'b0;
        end else if (bus_req) begin
            dec_region <= region;
            dec_sub <= cfg_hit ? sub : SUB_NONE;
            dec_offset <= bus_addr[OFF_W-1:0];
            dec_write <= bus_write && next_sel;
        end else begin
            dec_region <= REG_NONE;
            dec_sub <= SUB_NONE;
            dec_offset <= 16'h0000;
            dec_write <= 1'b0;
        end
    end

    assign pci_in_range = (pci_offset >= GUEST_LO) && (pci_offset <= GUEST_HI) && (pci_offset[1:0] == 2'h0);

    // PCI host path: select and write only in guest mode and only the guest slice
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pci_ack <= 1'b0;
            pci_sel <= 1'b0;
            pci_wr <= 1'b0;
            pci_off <= 16'h0000;
        end else begin
            pci_ack <= pci_req;
            pci_sel <= pci_req && guest_mode && pci_in_range;
            pci_wr <= pci_req && guest_mode && pci_in_range && pci_write;
            pci_off <= pci_req ? pci_offset : 16'h0000;
        end
    end

    sequence s_req;
        bus_req;
    endsequence

    sequence s_cfg_word;
        bus_req && word_ok && (bus_addr[ADDR_W-1:OFF_W] == cfg_base);
    endsequence

    sequence s_low_addr(logic [ADDR_W-1:0] hi);
        bus_req && (bus_addr <= hi) && (bus_addr[ADDR_W-1:OFF_W] != cfg_base);
    endsequence

    ack_follows_req_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        s_req |=> dec_ack ##1 (!dec_ack || $past(bus_req)))
        else $error("bus request not answered in one cycle");

    reloc_base_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        reloc_we ##1 (bus_req && word_ok && bus_addr[ADDR_W-1:OFF_W] == $past(reloc_base) && !reloc_we)
        |=> dec_region == REG_CFG && dec_sel == (dec_sub != SUB_NONE && dec_sub != SUB_RSVD))
        else $error("config block did not follow the new base");

    boot_map_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (s_low_addr(BOOT_HI) and (!app_map)) |=> dec_region == REG_BOOT && dec_sel)
        else $error("boot flash not selected in power-up map");

    sdram_map_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (s_low_addr(SDRAM_HI) and app_map) |=> dec_region == REG_SDRAM && dec_sel)
        else $error("sdram not selected in application map");

    size_refuse_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        bus_req && region == REG_CFG && bus_size != SIZE_WORD
        |=> dec_size_err && !dec_sel && !dec_write)
        else $error("non-word config access not refused");

    bridge_sel_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        s_cfg_word ##0 (bus_addr[OFF_W-1:0] >= 16'h2000 && bus_addr[OFF_W-1:0] <= 16'h2224)
        |=> dec_sub == SUB_BRIDGE && dec_sel)
        else $error("bridge configuration range not selected");

    reserved_hole_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        s_cfg_word ##0 (bus_addr[OFF_W-1:0] >= 16'ha000 && bus_addr[OFF_W-1:0] <= 16'ha0fc)
        |=> !dec_sel && (dec_rd_zero == !$past(bus_write)))
        else $error("reserved range selected a target");

    dma_sel_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        s_cfg_word ##0 (bus_addr[OFF_W-1:8] == 8'h60 || bus_addr[OFF_W-1:8] == 8'h80)
        |=> dec_sub == ($past(bus_addr[15]) ? SUB_LDMA : SUB_WDMA))
        else $error("dma range decoded to wrong group");

    guest_gate_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        pci_req && !guest_mode |=> pci_ack && !pci_sel && !pci_wr)
        else $error("pci host reached bridge outside guest mode");

    guest_strap_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $rose(guest_pin) ##1 guest_pin |=> guest_mode)
        else $error("guest strap not taken after two flops");

    unmapped_zero_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        bus_req && !bus_write && region == REG_NONE |=> dec_rd_zero && !dec_sel ##1 !dec_rd_zero || $past(bus_req))
        else $error("unmapped read did not return zero");

    sequence s_cfg_off(logic [OFF_W-1:0] lo, logic [OFF_W-1:0] hi);
        s_cfg_word ##0 (bus_addr[OFF_W-1:0] >= lo && bus_addr[OFF_W-1:0] <= hi);
    endsequence

    sequence s_app_hit(logic [ADDR_W-1:0] lo, logic [ADDR_W-1:0] hi);
        bus_req && app_map && (bus_addr >= lo) && (bus_addr <= hi) && (bus_addr[ADDR_W-1:OFF_W] != cfg_base);
    endsequence

    sys_sel_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        s_cfg_off(16'h0000, 16'h0004) |=> dec_sub == SUB_SYS && dec_sel)
        else $error("system registers not selected");

    memc_sel_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        s_cfg_off(16'h4000, 16'h4040) |=> dec_sub == SUB_MEMC && dec_sel)
        else $error("memory controller registers not selected");

    intc_sel_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        s_cfg_off(16'he200, 16'he234) |=> dec_sub == SUB_INTC && dec_sel)
        else $error("interrupt controller registers not selected");

    timer_sel_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        s_cfg_off(16'he400, 16'he410) |=> dec_sub == SUB_TIMER && dec_sel)
        else $error("timer registers not selected");

    gpio_sel_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        s_cfg_off(16'he600, 16'he608) |=> dec_sub == SUB_GPIO && dec_sel)
        else $error("general purpose io registers not selected");

    switch_sel_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        s_cfg_off(16'he800, 16'he850) |=> dec_sub == SUB_SWITCH && dec_sel)
        else $error("switch engine registers not selected");

    base_hold_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !reloc_we |=> $stable(cfg_base))
        else $error("config base moved without a load");

    base_load_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        reloc_we |=> cfg_base == $past(reloc_base))
        else $error("config base did not take the new value");

    idle_quiet_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !bus_req |=> !dec_ack && !dec_sel && !dec_write && !dec_rd_zero && !dec_size_err && dec_region == REG_NONE)
        else $error("decoder answered without a request");

    pu_gap_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        bus_req && !app_map && (bus_addr > BOOT_HI) && (bus_addr[ADDR_W-1:OFF_W] != cfg_base)
        |=> dec_region == REG_NONE && !dec_sel && !dec_write && (dec_rd_zero == !$past(bus_write)))
        else $error("power-up gap selected a target");

    size_cfg_only_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        bus_req && region != REG_CFG |=> !dec_size_err)
        else $error("size refused outside the config block");

    offset_pass_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        bus_req |=> dec_offset == $past(bus_addr[OFF_W-1:0]))
        else $error("offset not passed with the access");

    flash_map_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        s_app_hit(FLASH_LO, FLASH_HI) |=> dec_region == REG_FLASH && dec_sel)
        else $error("flash not selected in application map");

    xio_map_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        s_app_hit(XIO0_LO, XIO2_HI) |=> dec_sel && dec_region >= REG_XIO0)
        else $error("external io bank not selected in application map");

    app_gap_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        s_app_hit(SDRAM_HI + 26'h1, FLASH_LO - 26'h1) |=> dec_region == REG_NONE && !dec_sel)
        else $error("unused application space selected a target");

    pci_echo_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        pci_req |=> pci_ack && pci_off == $past(pci_offset))
        else $error("pci access not answered with its offset");

    guest_pass_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        pci_req && guest_mode && pci_in_range |=> pci_sel && (pci_wr == $past(pci_write)))
        else $error("pci host refused inside the guest slice");

    pci_range_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        pci_req && !pci_in_range |=> !pci_sel && !pci_wr)
        else $error("pci host reached outside the guest slice");
endmodule : sysad_decoder

// ==== test/sysad_cpu_model.sv ====
/*
 * Bus master model standing in for the embedded core on the system bus.
 * Assumes each task is entered just after a rising edge of core_clk.
 */
`timescale 1ns/1ps
module sysad_cpu_model import sysad_pkg::*; (
    input wire logic core_clk,          // system clock
    output logic bus_req,               // access request
    output logic bus_write,             // write qualifier
    output logic [ADDR_W-1:0] bus_addr, // byte address
    output logic [1:0] bus_size         // transfer size
);
    initial begin
        bus_req = 1'b0;
        bus_write = 1'b0;
        bus_addr = '0;
        bus_size = SIZE_WORD;
    end
    // one access per edge; calls in a row give back-to-back requests
    task automatic access(input logic wr, input logic [ADDR_W-1:0] addr, input logic [1:0] size);
        bus_req = 1'b1;
        bus_write = wr;
        bus_addr = addr;
        bus_size = size;
        @(posedge core_clk);
        #1;
    endtask : access
    // released lines show the inverse of their last value
    task automatic idle();
        bus_req = 1'b0;
        bus_write = ~bus_write;
        bus_addr = ~bus_addr;
        bus_size = ~bus_size;
        @(posedge core_clk);
        #1;
    endtask : idle
endmodule : sysad_cpu_model

// ==== test/tb_top.sv ====
/*
 * Self-checking bench for the system address decoder.
 * Assumes the decoder answers every request one cycle after it is taken.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_top import sysad_pkg::*;;
    logic core_clk = 1'b0, rst_n = 1'b0, bus_req, bus_write, app_map = 1'b0, reloc_we = 1'b0;
    logic guest_pin = 1'b0, pci_req = 1'b0, pci_write = 1'b0;
    logic [ADDR_W-1:0] bus_addr;
    logic [1:0] bus_size;
    logic [BASE_W-1:0] reloc_base = '0;
    logic [OFF_W-1:0] pci_offset = '0;
    logic dec_ack, dec_write, dec_sel, dec_size_err, dec_rd_zero, guest_mode, pci_ack, pci_sel, pci_wr;
    sysad_region_t dec_region;
    sysad_sub_t dec_sub;
    logic [OFF_W-1:0] dec_offset, pci_off;
    logic [BASE_W-1:0] cfg_base;
    int fail_count = 0, compares = 0;
    always #12.5 core_clk = ~core_clk;
    sysad_cpu_model cpu (.core_clk(core_clk), .bus_req(bus_req), .bus_write(bus_write),
        .bus_addr(bus_addr), .bus_size(bus_size));
    sysad_decoder DUT (.core_clk(core_clk), .rst_n(rst_n), .bus_req(bus_req), .bus_write(bus_write),
        .bus_addr(bus_addr), .bus_size(bus_size), .app_map(app_map), .reloc_we(reloc_we),
        .reloc_base(reloc_base), .guest_pin(guest_pin), .pci_req(pci_req), .pci_write(pci_write),
        .pci_offset(pci_offset), .dec_ack(dec_ack), .dec_region(dec_region), .dec_sub(dec_sub),
        .dec_offset(dec_offset), .dec_write(dec_write), .dec_sel(dec_sel), .dec_size_err(dec_size_err),
        .dec_rd_zero(dec_rd_zero), .cfg_base(cfg_base), .guest_mode(guest_mode), .pci_ack(pci_ack),
        .pci_sel(pci_sel), .pci_wr(pci_wr), .pci_off(pci_off));
    localparam logic [25:0] PU_A [15] = '{26'h3ff0000, 26'h3ff2224, 26'h3ff4040, 26'h3ff6000,
        26'h3ff80fc, 26'h3ffa000, 26'h3ffe000, 26'h3ffe234, 26'h3ffe400, 26'h3ffe608, 26'h3ffe850,
        26'h3ffea18, 26'h3ff2228, 26'h1fffffc, 26'h2000000};
    localparam sysad_sub_t PU_S [15] = '{SUB_SYS, SUB_BRIDGE, SUB_MEMC, SUB_WDMA, SUB_LDMA, SUB_RSVD,
        SUB_UART, SUB_INTC, SUB_TIMER, SUB_GPIO, SUB_SWITCH, SUB_MISC, SUB_NONE, SUB_NONE, SUB_NONE};
    localparam logic [25:0] AP_A [9] = '{26'h0000000, 26'h0fffffc, 26'h1000000, 26'h2800000,
        26'h2c00000, 26'h3200000, 26'h3600000, 26'h3a00000, 26'h3ff0000};
    localparam sysad_region_t AP_R [9] = '{REG_SDRAM, REG_SDRAM, REG_NONE, REG_FLASH, REG_NONE,
        REG_XIO0, REG_XIO1, REG_XIO2, REG_CFG};
    // outputs of the access taken at the previous edge
    task automatic chk_acc(input sysad_region_t r, input sysad_sub_t s, input logic sel, input logic wr,
        input logic [15:0] off);
        `CHK("dec_ack", 1'b1, dec_ack)
        `CHK("dec_region", r, dec_region)
        `CHK("dec_sub", s, dec_sub)
        `CHK("dec_sel", sel, dec_sel)
        `CHK("dec_rd_zero", !wr && !sel, dec_rd_zero)
        `CHK("dec_write", wr && sel, dec_write)
        `CHK("dec_size_err", 1'b0, dec_size_err)
        `CHK("dec_offset", off, dec_offset)
    endtask : chk_acc
    task automatic t_powerup();
        for (int i = 0; i < 15; i++) begin
            cpu.access(1'b0, PU_A[i], SIZE_WORD);
            chk_acc(i < 13 ? REG_CFG : (i == 13 ? REG_BOOT : REG_NONE), PU_S[i],
                !(i == 5 || i == 12 || i == 14), 1'b0, PU_A[i][15:0]);
        end
        cpu.access(1'b1, 26'h3ffe410, SIZE_WORD);
        chk_acc(REG_CFG, SUB_TIMER, 1'b1, 1'b1, 16'he410);
        cpu.idle();
    endtask : t_powerup
    task automatic t_app_map();
        app_map = 1'b1;
        for (int i = 0; i < 9; i++) begin
            cpu.access(1'b0, AP_A[i], SIZE_WORD);
            chk_acc(AP_R[i], i == 8 ? SUB_SYS : SUB_NONE, AP_R[i] != REG_NONE, 1'b0, AP_A[i][15:0]);
        end
        cpu.idle();
        app_map = 1'b0;
    endtask : t_app_map
    task automatic t_size();
        logic [25:0] a [3] = '{26'h3ffe400, 26'h3ffe400, 26'h3ffe402};
        logic [1:0] z [3] = '{SIZE_BYTE, SIZE_HALF, SIZE_WORD};
        for (int i = 0; i < 3; i++) begin
            cpu.access(1'b1, a[i], z[i]);
            `CHK("size_err", 1'b1, dec_size_err)
            `CHK("sel", 1'b0, dec_sel)
            `CHK("write", 1'b0, dec_write)
        end
        cpu.access(1'b1, 26'h0000010, SIZE_BYTE);
        chk_acc(REG_BOOT, SUB_NONE, 1'b1, 1'b1, 16'h0010);
        cpu.idle();
    endtask : t_size
    task automatic t_reloc();
        `CHK("cfg_base", 10'h3ff, cfg_base)
        reloc_we = 1'b1;
        reloc_base = 10'h020;
        @(posedge core_clk);
        #1;
        reloc_we = 1'b0;
        `CHK("cfg_base", 10'h020, cfg_base)
        cpu.access(1'b0, 26'h0202000, SIZE_WORD);
        chk_acc(REG_CFG, SUB_BRIDGE, 1'b1, 1'b0, 16'h2000);
        cpu.access(1'b0, 26'h3ff0000, SIZE_WORD);
        chk_acc(REG_NONE, SUB_NONE, 1'b0, 1'b0, 16'h0000);
        cpu.idle();
        rst_n = 1'b0;
        #1;
        `CHK("cfg_base", 10'h3ff, cfg_base)
        @(posedge core_clk);
        #1;
        rst_n = 1'b1;
    endtask : t_reloc
    task automatic pci_acc(input logic wr, input logic [15:0] off, input logic sel);
        pci_req = 1'b1;
        pci_write = wr;
        pci_offset = off;
        @(posedge core_clk);
        #1;
        pci_req = 1'b0;
        `CHK("pci_ack", 1'b1, pci_ack)
        `CHK("pci_sel", sel, pci_sel)
        `CHK("pci_wr", sel && wr, pci_wr)
        `CHK("pci_off", off, pci_off)
        @(posedge core_clk);
        #1;
    endtask : pci_acc
    task automatic t_pci();
        pci_acc(1'b1, 16'h2004, 1'b0);
        guest_pin = 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        `CHK("guest_mode", 1'b1, guest_mode)
        pci_acc(1'b1, 16'h2004, 1'b1);
        pci_acc(1'b0, 16'h20fc, 1'b1);
        pci_acc(1'b1, 16'h2100, 1'b0);
        pci_acc(1'b1, 16'h2006, 1'b0);
    endtask : t_pci
    task automatic final_report();
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report
    initial begin
        @(posedge core_clk);
        #1;
        `CHK("cfg_base", 10'h3ff, cfg_base)
        repeat (4) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        t_powerup();
        t_app_map();
        t_size();
        t_reloc();
        t_pci();
        final_report();
    end
    initial begin
        #20000;
        fail_count++;
        final_report();
    end
endmodule : tb_top
